// File: idu_pkg.sv
package idu_pkg;
    localparam int IDU_XLEN = 64;
    localparam int IDU_WLEN = 32;
    localparam int IDU_CNT_W = 7;
    localparam logic [3:0] IDU_REL_DEFAULT = 4'h2;
    localparam logic [3:0] IDU_REL_NO_DWORD = 4'h6;
    localparam logic [IDU_CNT_W-1:0] IDU_WORD_STEPS = 7'h20;
    localparam logic [IDU_CNT_W-1:0] IDU_DWORD_STEPS = 7'h40;
    typedef enum logic [1:0] {
        IDU_OP_WORD_SIGNED = 2'b00,
        IDU_OP_DWORD_SIGNED = 2'b01,
        IDU_OP_DWORD_UNSIGNED = 2'b10,
        IDU_OP_RSVD = 2'b11
    } idu_op_t;
    typedef enum logic [1:0] {
        IDU_ST_IDLE = 2'b00,
        IDU_ST_RUN = 2'b01,
        IDU_ST_FIX = 2'b10
    } idu_state_t;
endpackage

// File: idu_step_if.sv
`timescale 1ns/1ps
`default_nettype none
interface idu_step_if #(parameter int W = 64);
    logic [W-1:0] rem_cur;
    logic [W-1:0] quo_cur;
    logic [W-1:0] divisor;
    logic [W-1:0] rem_next;
    logic [W-1:0] quo_next;
    modport ctrl (output rem_cur, output quo_cur, output divisor,
        input rem_next, input quo_next);
    modport step (input rem_cur, input quo_cur, input divisor,
        output rem_next, output quo_next);
endinterface
`default_nettype wire

// File: idu_step.sv
`timescale 1ns/1ps
`default_nettype none
module idu_step #(
    parameter int W = 64
) (
    idu_step_if.step s
);
    logic [W:0] shifted;
    logic [W:0] diff;
    // One restoring division step
    always_comb begin
        shifted = {s.rem_cur, s.quo_cur[W-1]};
        diff = shifted - {1'b0, s.divisor};
        if (!diff[W]) begin
            s.rem_next = diff[W-1:0];
            s.quo_next = {s.quo_cur[W-2:0], 1'b1};
        end else begin
            s.rem_next = shifted[W-1:0];
            s.quo_next = {s.quo_cur[W-2:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

// File: idu_divide_unit.sv
`timescale 1ns/1ps
`default_nettype none
module idu_divide_unit
    import idu_pkg::*;
#(
    parameter int XLEN = IDU_XLEN,
    parameter logic [3:0] RELEASE_LEVEL = IDU_REL_DEFAULT
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic start_in,
    input wire logic [1:0] op_in,
    input wire logic [XLEN-1:0] dividend_in,
    input wire logic [XLEN-1:0] divisor_in,
    input wire logic move_from_lower_result_in,
    input wire logic move_from_upper_result_in,
    output logic busy_out,
    output logic done_out,
    output logic rsvd_instr_exc_out,
    output logic arith_exc_out,
    output logic read_stall_out,
    output logic read_valid_out,
    output logic [XLEN-1:0] read_data_out,
    output logic [XLEN-1:0] lower_result_reg_out,
    output logic [XLEN-1:0] upper_result_reg_out
);
    idu_state_t state_r;
    logic [IDU_CNT_W-1:0] count_r;
    logic [XLEN-1:0] rem_r;
    logic [XLEN-1:0] quo_r;
    logic [XLEN-1:0] dvs_r;
    logic neg_quo_r;
    logic neg_rem_r;
    logic word_r;
    logic pend_lo_r;
    logic pend_hi_r;
    logic accept;
    logic is_dword;
    logic reject;
    logic sgn_a;
    logic sgn_b;
    logic [XLEN-1:0] a_ext;
    logic [XLEN-1:0] b_ext;
    logic [XLEN-1:0] q_fix;
    logic [XLEN-1:0] r_fix;
    logic rd_req;
    logic [XLEN-1:0] a_mag;

    idu_step_if #(.W(XLEN)) st ();

    idu_step #(.W(XLEN)) u_step (
        .s(st)
    );

    function automatic logic [XLEN-1:0] abs_val(input logic [XLEN-1:0] v, input logic neg);
        abs_val = neg ? (~v + {{(XLEN-1){1'b0}}, 1'b1}) : v;
    endfunction

    function automatic logic [XLEN-1:0] sext32(input logic [XLEN-1:0] v);
        sext32 = {{(XLEN-IDU_WLEN){v[IDU_WLEN-1]}}, v[IDU_WLEN-1:0]};
    endfunction

    assign is_dword = (op_in == IDU_OP_DWORD_SIGNED) || (op_in == IDU_OP_DWORD_UNSIGNED);
    assign reject = (op_in == IDU_OP_RSVD) || (is_dword && (RELEASE_LEVEL >= IDU_REL_NO_DWORD));
    assign accept = start_in && (state_r == IDU_ST_IDLE) && !reject;
    assign rd_req = move_from_lower_result_in || move_from_upper_result_in;
    assign a_mag = abs_val(a_ext, sgn_a);

    always_comb begin
        a_ext = dividend_in;
        b_ext = divisor_in;
        sgn_a = 1'b0;
        sgn_b = 1'b0;
        unique case (op_in)
            IDU_OP_WORD_SIGNED: begin
                a_ext = sext32(dividend_in);
                b_ext = sext32(divisor_in);
                sgn_a = dividend_in[IDU_WLEN-1];
                sgn_b = divisor_in[IDU_WLEN-1];
            end
            IDU_OP_DWORD_SIGNED: begin
                sgn_a = dividend_in[XLEN-1];
                sgn_b = divisor_in[XLEN-1];
            end
            IDU_OP_DWORD_UNSIGNED: begin
                sgn_a = 1'b0;
                sgn_b = 1'b0;
            end
            IDU_OP_RSVD: begin
                sgn_a = 1'b0;
                sgn_b = 1'b0;
            end
        endcase
    end

    assign st.rem_cur = rem_r;
    assign st.quo_cur = quo_r;
    assign st.divisor = dvs_r;

    // Sign correction; truncated division, remainder takes the dividend sign
    assign q_fix = abs_val(quo_r, neg_quo_r);
    assign r_fix = abs_val(rem_r, neg_rem_r);

    // Sequencer
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state_r <= IDU_ST_IDLE;
            count_r <= '0;
        end else if (clk_en_in) begin
            unique case (state_r)
                IDU_ST_IDLE: begin
                    if (accept) begin
                        state_r <= IDU_ST_RUN;
                        count_r <= (op_in == IDU_OP_WORD_SIGNED) ? IDU_WORD_STEPS : IDU_DWORD_STEPS;
                    end
                end
                IDU_ST_RUN: begin
                    count_r <= count_r - 7'h01;
                    if (count_r == 7'h01) begin
                        state_r <= IDU_ST_FIX;
                    end
                end
                IDU_ST_FIX: begin
                    state_r <= IDU_ST_IDLE;
                end
                default: begin
                    state_r <= IDU_ST_IDLE;
                end
            endcase
        end
    end

    // Datapath
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rem_r <= '0;
            quo_r <= '0;
            dvs_r <= '0;
            neg_quo_r <= 1'b0;
            neg_rem_r <= 1'b0;
            word_r <= 1'b0;
        end else if (clk_en_in) begin
            if (accept) begin
                rem_r <= '0;
                word_r <= (op_in == IDU_OP_WORD_SIGNED);
                neg_quo_r <= sgn_a ^ sgn_b;
                neg_rem_r <= sgn_a;
                dvs_r <= abs_val(b_ext, sgn_b);
                if (op_in == IDU_OP_WORD_SIGNED) begin
                    quo_r <= {a_mag[IDU_WLEN-1:0], {(XLEN-IDU_WLEN){1'b0}}};
                end else begin
                    quo_r <= a_mag;
                end
            end else if (state_r == IDU_ST_RUN) begin
                rem_r <= st.rem_next;
                quo_r <= st.quo_next;
            end
        end
    end

    // Result registers and status
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            lower_result_reg_out <= '0;
            upper_result_reg_out <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rsvd_instr_exc_out <= 1'b0;
            arith_exc_out <= 1'b0;
        end else if (clk_en_in) begin
            done_out <= 1'b0;
            arith_exc_out <= 1'b0;
            rsvd_instr_exc_out <= start_in && (state_r == IDU_ST_IDLE) && reject;
            if (accept) begin
                busy_out <= 1'b1;
            end else if (state_r == IDU_ST_FIX) begin
                busy_out <= 1'b0;
                done_out <= 1'b1;
                if (word_r) begin
                    lower_result_reg_out <= sext32(q_fix);
                    upper_result_reg_out <= sext32(r_fix);
                end else begin
                    lower_result_reg_out <= q_fix;
                    upper_result_reg_out <= r_fix;
                end
            end
        end
    end

    // Result moves: served from the registers, held while a divide runs
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pend_lo_r <= 1'b0;
            pend_hi_r <= 1'b0;
            read_valid_out <= 1'b0;
            read_stall_out <= 1'b0;
            read_data_out <= '0;
        end else if (clk_en_in) begin
            read_valid_out <= 1'b0;
            if (state_r == IDU_ST_IDLE && !pend_lo_r && !pend_hi_r) begin
                read_stall_out <= 1'b0;
                if (rd_req) begin
                    read_valid_out <= 1'b1;
                    read_data_out <= move_from_upper_result_in ? upper_result_reg_out
                                                               : lower_result_reg_out;
                end
            end else if (state_r == IDU_ST_IDLE) begin
                read_stall_out <= 1'b0;
                read_valid_out <= 1'b1;
                read_data_out <= pend_hi_r ? upper_result_reg_out : lower_result_reg_out;
                pend_lo_r <= 1'b0;
                pend_hi_r <= 1'b0;
            end else if (rd_req || pend_lo_r || pend_hi_r) begin
                read_stall_out <= 1'b1;
                if (rd_req) begin
                    pend_hi_r <= move_from_upper_result_in;
                    pend_lo_r <= !move_from_upper_result_in;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: idu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module idu_monitor
    import idu_pkg::*;
#(
    parameter int XLEN = IDU_XLEN,
    parameter logic [3:0] RELEASE_LEVEL = IDU_REL_DEFAULT
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input wire logic [1:0] op_in,
    input wire logic move_from_lower_result_in,
    input wire logic move_from_upper_result_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic rsvd_instr_exc_out,
    input wire logic arith_exc_out,
    input wire logic read_stall_out,
    input wire logic read_valid_out,
    input wire logic [XLEN-1:0] read_data_out,
    input wire logic [XLEN-1:0] lower_result_reg_out,
    input wire logic [XLEN-1:0] upper_result_reg_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    wire acc = start_in && !busy_out && !done_out;
    wire bad = op_in == 2'h3 || (op_in != 2'h0 && RELEASE_LEVEL >= IDU_REL_NO_DWORD);
    wire rd = move_from_lower_result_in || move_from_upper_result_in;
    a_no_arith: assert property (!arith_exc_out) else $error("arith exc");
    a_word_done: assert property (acc && op_in == 2'h0 |-> ##34 done_out)
        else $error("word latency");
    a_dword_done: assert property (acc && op_in != 2'h0 && !bad |-> ##66 done_out)
        else $error("dword latency");
    a_busy_run: assert property (acc && !bad |=> busy_out [*8])
        else $error("busy dropped");
    a_reject_op: assert property (acc && bad |=> rsvd_instr_exc_out && !busy_out)
        else $error("no reject");
    a_read_stall: assert property (rd && busy_out |=> read_stall_out)
        else $error("no stall");
    a_idle_read: assert property (rd && !busy_out && !done_out && !read_stall_out |=>
        read_valid_out && read_data_out == ($past(move_from_upper_result_in) ?
        $past(upper_result_reg_out) : $past(lower_result_reg_out))) else $error("read");
    a_result_hold: assert property (!done_out |-> $stable(lower_result_reg_out) &&
        $stable(upper_result_reg_out)) else $error("result moved");
endmodule
bind idu_divide_unit idu_monitor #(.XLEN(XLEN), .RELEASE_LEVEL(RELEASE_LEVEL)) mon_u (
    .core_clk_in, .sys_rst_in, .start_in, .op_in, .move_from_lower_result_in,
    .move_from_upper_result_in, .busy_out, .done_out, .rsvd_instr_exc_out, .arith_exc_out,
    .read_stall_out, .read_valid_out, .read_data_out, .lower_result_reg_out,
    .upper_result_reg_out);
`default_nettype wire

// File: idu_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module idu_pipe_model (
    input wire logic core_clk_in,
    input wire logic rd_go_in,
    input wire logic rd_upper_in,
    input wire logic read_valid_in,
    input wire logic [63:0] read_data_in,
    output logic mfl_out,
    output logic mfu_out,
    output logic rd_done_out,
    output logic [63:0] rd_data_out
);
    logic wait_r = 1'b0;
    logic mfl_r = 1'b0;
    logic mfu_r = 1'b0;
    initial {mfl_out, mfu_out, rd_done_out} = 3'h0;
    // Request pins change on the falling edge, one cycle wide
    always @(negedge core_clk_in) begin
        mfl_out <= mfl_r;
        mfu_out <= mfu_r;
    end
    // One-cycle read request, then waits out any stall
    always @(posedge core_clk_in) begin
        mfl_r <= rd_go_in && !rd_upper_in;
        mfu_r <= rd_go_in && rd_upper_in;
        rd_done_out <= wait_r && read_valid_in;
        if (rd_go_in)
            wait_r <= 1'b1;
        else if (wait_r && read_valid_in) begin
            wait_r <= 1'b0;
            rd_data_out <= read_data_in;
        end
    end
endmodule
`default_nettype wire

// File: idu_divide_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module idu_divide_unit_bench;
    logic clk = 1'b0, rst = 1'b1, st = 1'b0, go = 1'b0, up = 1'b0;
    logic [1:0] op = 2'h0;
    logic [63:0] a = 64'h0, b = 64'h0;
    wire logic busy, done, rsvd, aexc, stall, vld, mfl, mfu, rdone;
    wire logic [63:0] rdat, lo, hi, pdat;
    wire logic busy6, rsvd6;
    int n_fail = 0, total_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    idu_divide_unit dut_u (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1), .start_in(st),
        .op_in(op), .dividend_in(a), .divisor_in(b), .move_from_lower_result_in(mfl),
        .move_from_upper_result_in(mfu), .busy_out(busy), .done_out(done),
        .rsvd_instr_exc_out(rsvd), .arith_exc_out(aexc), .read_stall_out(stall),
        .read_valid_out(vld), .read_data_out(rdat), .lower_result_reg_out(lo),
        .upper_result_reg_out(hi));
    idu_divide_unit #(.RELEASE_LEVEL(idu_pkg::IDU_REL_NO_DWORD)) dut_r6_u (.core_clk_in(clk),
        .sys_rst_in(rst), .clk_en_in(1'b1), .start_in(st), .op_in(op), .dividend_in(a),
        .divisor_in(b), .move_from_lower_result_in(mfl), .move_from_upper_result_in(mfu),
        .busy_out(busy6), .done_out(), .rsvd_instr_exc_out(rsvd6), .arith_exc_out(),
        .read_stall_out(), .read_valid_out(), .read_data_out(), .lower_result_reg_out(),
        .upper_result_reg_out());
    idu_pipe_model pipe_u (.core_clk_in(clk), .rd_go_in(go), .rd_upper_in(up),
        .read_valid_in(vld), .read_data_in(rdat), .mfl_out(mfl), .mfu_out(mfu),
        .rd_done_out(rdone), .rd_data_out(pdat));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic launch(input logic [1:0] o, input logic [63:0] x, input logic [63:0] y);
        op = o;
        a = x;
        b = y;
        st = 1'b1;
        @(negedge clk);
        st = 1'b0;
    endtask
    task automatic wt();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        chk(64'h1, {63'h0, done});
        @(negedge clk);
    endtask
    task automatic dv(input logic [1:0] o, input logic [63:0] x, y, q, r);
        launch(o, x, y);
        wt();
        chk(q, lo);
        chk(r, hi);
    endtask
    task automatic t_ops();
        dv(2'h0, 64'h12345678FFFFFF9C, 64'h7, 64'hFFFFFFFFFFFFFFF2, 64'hFFFFFFFFFFFFFFFE);
        dv(2'h0, 64'h80000000, 64'hFFFFFFFF, 64'hFFFFFFFF80000000, 64'h0);
        dv(2'h1, 64'h8000000000000000, 64'h3, 64'hD555555555555556, 64'hFFFFFFFFFFFFFFFE);
        dv(2'h2, 64'h8000000000000000, 64'h3, 64'h2AAAAAAAAAAAAAAA, 64'h2);
        dv(2'h1, 64'h8000000000000000, 64'hFFFFFFFFFFFFFFFF, 64'h8000000000000000, 64'h0);
        launch(2'h2, 64'h5, 64'h0);
        wt();
        chk(64'h0, {63'h0, aexc});
        $display("test ops end");
    endtask
    task automatic t_busy();
        launch(2'h0, 64'h64, 64'h7);
        @(negedge clk);
        launch(2'h0, 64'h9, 64'h3);
        wt();
        chk(64'hE, lo);
        chk(64'h2, hi);
        $display("test busy end");
    endtask
    task automatic t_read();
        int n;
        go = 1'b1;
        up = 1'b1;
        @(negedge clk);
        go = 1'b0;
        @(negedge clk);
        launch(2'h0, 64'hFFFFFFFFFFFFFF9C, 64'h7);
        chk(64'h1, {63'h0, rdone});
        chk(64'h2, pdat);
        go = 1'b1;
        up = 1'b0;
        @(negedge clk);
        go = 1'b0;
        repeat (2) @(negedge clk);
        chk(64'h1, {63'h0, stall});
        n = 0;
        while (rdone !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        chk(64'hFFFFFFFFFFFFFFF2, pdat);
        $display("test read end");
    endtask
    task automatic t_rsvd();
        launch(2'h3, 64'h9, 64'h3);
        chk(64'h1, {63'h0, rsvd});
        chk(64'h0, {63'h0, busy});
        @(negedge clk);
        launch(2'h1, 64'hFFFFFFFFFFFFFFF7, 64'h3);
        chk(64'h1, {63'h0, rsvd6});
        chk(64'h0, {63'h0, busy6});
        chk(64'h0, {63'h0, rsvd});
        wt();
        chk(64'hFFFFFFFFFFFFFFFD, lo);
        chk(64'h0, hi);
        $display("test reserved end");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_ops();
        t_busy();
        t_read();
        t_rsvd();
        test_done();
    end
endmodule
`default_nettype wire
